// File: wtcts_pkg.sv
// Purpose: Constants shared by the weekly three cam time switch
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Weekday is 0..6, hour 0..23, minute 0..59
`default_nettype none
package wtcts_pkg;
  localparam int WTCTS_NUM_CAMS = 3;
  localparam int WTCTS_ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] WTCTS_CTRL_OFF = 8'h00;
  localparam logic [7:0] WTCTS_STAT_OFF = 8'h04;
  localparam logic [7:0] WTCTS_CAM0_OFF = 8'h10;
  localparam logic [7:0] WTCTS_CAM_STRIDE = 8'h04;
  // Control fields
  localparam int WTCTS_CTRL_EN_BIT = 0;
  localparam int WTCTS_CTRL_PULSE_BIT = 1;
  // Cam word fields
  localparam int WTCTS_CAM_DAYS_LSB = 0;
  localparam int WTCTS_CAM_ONMIN_LSB = 7;
  localparam int WTCTS_CAM_ONHR_LSB = 13;
  localparam int WTCTS_CAM_ONDIS_BIT = 18;
  localparam int WTCTS_CAM_OFFMIN_LSB = 19;
  localparam int WTCTS_CAM_OFFHR_LSB = 25;
  localparam int WTCTS_CAM_OFFDIS_BIT = 30;
  localparam logic [30:0] WTCTS_CAM_RESET = 31'h40040000;
  localparam logic [30:0] WTCTS_CAM_MASK = 31'h7FFFFFFF;
  // Time limits
  localparam logic [4:0] WTCTS_HOUR_MAX = 5'h17;
  localparam logic [5:0] WTCTS_MIN_MAX = 6'h3B;
  localparam logic [2:0] WTCTS_DAY_MAX = 3'h6;
endpackage : wtcts_pkg
`default_nettype wire

// File: wtcts_cam_if.sv
// Purpose: Carries one cam's settings and match results
// Assumes: Same clock domain on both sides
// Notes: Cfg side drives settings, match side returns events
`default_nettype none
interface wtcts_cam_if;
  logic [6:0] days;
  logic [4:0] on_hour;
  logic [5:0] on_min;
  logic on_dis;
  logic [4:0] off_hour;
  logic [5:0] off_min;
  logic off_dis;
  logic on_hit;
  logic off_hit;
  modport cfg (output days, on_hour, on_min, on_dis, off_hour, off_min, off_dis,
    input on_hit, off_hit);
  modport cam (input days, on_hour, on_min, on_dis, off_hour, off_min, off_dis,
    output on_hit, off_hit);
endinterface : wtcts_cam_if
`default_nettype wire

// File: wtcts_cam.sv
// Purpose: Compares the calendar time against one cam
// Assumes: Time inputs already synchronised
// Notes: Combinational match only
`default_nettype none
module wtcts_cam
  import wtcts_pkg::*;
(
  // Current time
  input wire logic [2:0] day_i,
  input wire logic [4:0] hour_i,
  input wire logic [5:0] min_i,
  // Cam settings and results
  wtcts_cam_if.cam cam_if
);
  ////////////////////////////////////////////////////////////////////////////
  // Day selected and time equal, disabled times never match
  assign cam_if.on_hit = cam_if.days[day_i] && !cam_if.on_dis &&
    hour_i == cam_if.on_hour && min_i == cam_if.on_min;
  assign cam_if.off_hit = cam_if.days[day_i] && !cam_if.off_dis &&
    hour_i == cam_if.off_hour && min_i == cam_if.off_min;
endmodule : wtcts_cam
`default_nettype wire

// File: wtcts_top.sv
// Purpose: Weekly three cam time switch with APB register access
// Assumes: Calendar time arrives from another domain with a valid flag
// Notes: Events are evaluated once per minute change of the calendar
//
// The APB register port and the placing of the registers were chosen for this implementation.
`default_nettype none
module wtcts_top
  import wtcts_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Calendar clock
  input wire logic rtc_valid_i,
  input wire logic [2:0] rtc_day_i,
  input wire logic [4:0] rtc_hour_i,
  input wire logic [5:0] rtc_min_i,
  // Switch output
  output logic switch_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [14:0] rtc_s1;
  logic [14:0] rtc_s2;
  logic [14:0] rtc_last;
  logic ctrl_en;
  logic ctrl_pulse;
  logic [30:0] cam_cfg [WTCTS_NUM_CAMS];
  logic [WTCTS_NUM_CAMS-1:0] on_hit;
  logic [WTCTS_NUM_CAMS-1:0] off_hit;
  logic time_ok;
  logic minute_tick;
  logic next_switch;
  logic apb_write;
  logic apb_read;
  logic [31:0] next_rdata;
  logic next_err;
  logic [2:0] cur_day;
  logic [4:0] cur_hour;
  logic [5:0] cur_min;

  // Returns cam index hit by an address, or NUM_CAMS when none
  function automatic int cam_index(input logic [7:0] addr);
    int idx;
    idx = WTCTS_NUM_CAMS;
    for (int k = 0; k < WTCTS_NUM_CAMS; k++) begin
      if (addr == 8'(WTCTS_CAM0_OFF + 8'(k) * WTCTS_CAM_STRIDE)) begin
        idx = k;
      end
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser for calendar time and valid flag
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rtc_s1 <= 15'h0000;
      rtc_s2 <= 15'h0000;
    end else begin
      rtc_s1 <= {rtc_valid_i, rtc_day_i, rtc_hour_i, rtc_min_i};
      rtc_s2 <= rtc_s1;
    end
  end

  assign cur_day = rtc_s2[13:11];
  assign cur_hour = rtc_s2[10:6];
  assign cur_min = rtc_s2[5:0];

  ////////////////////////////////////////////////////////////////////////////
  // Time is usable only when valid and within range
  assign time_ok = rtc_s2[14] && cur_day <= WTCTS_DAY_MAX &&
    cur_hour <= WTCTS_HOUR_MAX && cur_min <= WTCTS_MIN_MAX;

  // Remember the synchronised time of the previous cycle, whether or not it was evaluated
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rtc_last <= 15'h0000;
    end else begin
      rtc_last <= rtc_s2;
    end
  end

  // One tick per minute change while running
  assign minute_tick = ctrl_en && time_ok && (rtc_s2 != rtc_last);

  ////////////////////////////////////////////////////////////////////////////
  // Cam comparators
  for (genvar g = 0; g < WTCTS_NUM_CAMS; g++) begin : g_cam
    wtcts_cam_if cif ();
    assign cif.days = cam_cfg[g][WTCTS_CAM_DAYS_LSB +: 7];
    assign cif.on_min = cam_cfg[g][WTCTS_CAM_ONMIN_LSB +: 6];
    assign cif.on_hour = cam_cfg[g][WTCTS_CAM_ONHR_LSB +: 5];
    assign cif.on_dis = cam_cfg[g][WTCTS_CAM_ONDIS_BIT];
    assign cif.off_min = cam_cfg[g][WTCTS_CAM_OFFMIN_LSB +: 6];
    assign cif.off_hour = cam_cfg[g][WTCTS_CAM_OFFHR_LSB +: 5];
    assign cif.off_dis = cam_cfg[g][WTCTS_CAM_OFFDIS_BIT];
    wtcts_cam u_cam (
      .day_i(cur_day),
      .hour_i(cur_hour),
      .min_i(cur_min),
      .cam_if(cif.cam)
    );
    assign on_hit[g] = cif.on_hit;
    assign off_hit[g] = cif.off_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combine events; the highest cam with an event decides, and off events count only while ctrl_pulse is off
  always_comb begin
    next_switch = switch_o;
    if (ctrl_pulse && switch_o) begin
      next_switch = 1'b0;
    end
    if (minute_tick) begin
      for (int k = 0; k < WTCTS_NUM_CAMS; k++) begin
        if (on_hit[k]) begin
          next_switch = !(ctrl_pulse && switch_o);
          if (!ctrl_pulse) begin
            next_switch = 1'b1;
          end
        end else if (off_hit[k] && !ctrl_pulse) begin
          next_switch = 1'b0;
        end
      end
    end
  end

  // Output state changed by cam events, and cleared one cycle after it sets while ctrl_pulse is on
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      switch_o <= 1'b0;
    end else begin
      switch_o <= next_switch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: answer on the first access cycle
  assign apb_write = psel_i && penable_i && pwrite_i;
  assign apb_read = psel_i && !penable_i && !pwrite_i;

  // Control register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_en <= 1'b0;
      ctrl_pulse <= 1'b0;
    end else if (apb_write && paddr_i == WTCTS_CTRL_OFF) begin
      ctrl_en <= pwdata_i[WTCTS_CTRL_EN_BIT];
      ctrl_pulse <= pwdata_i[WTCTS_CTRL_PULSE_BIT];
    end
  end

  // Cam setting registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int k = 0; k < WTCTS_NUM_CAMS; k++) begin
        cam_cfg[k] <= WTCTS_CAM_RESET;
      end
    end else if (apb_write && cam_index(paddr_i) < WTCTS_NUM_CAMS) begin
      cam_cfg[cam_index(paddr_i)] <= pwdata_i[30:0] & WTCTS_CAM_MASK;
    end
  end

  // Read data and error for the coming access cycle
  always_comb begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (paddr_i == WTCTS_CTRL_OFF) begin
      next_rdata = {30'h00000000, ctrl_pulse, ctrl_en};
    end else if (paddr_i == WTCTS_STAT_OFF) begin
      next_rdata = {15'h0000, time_ok, switch_o, rtc_s2};
    end else if (cam_index(paddr_i) < WTCTS_NUM_CAMS) begin
      next_rdata = {1'b0, cam_cfg[cam_index(paddr_i)]};
    end else begin
      next_err = 1'b1;
    end
  end

  // Registered APB answer, valid in the access phase
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && next_err;
      if (apb_read) begin
        prdata_o <= next_rdata;
      end
    end
  end
endmodule : wtcts_top
`default_nettype wire

// File: wtcts_asserts.sv
// Purpose: Port checks for the weekly three cam time switch
// Assumes: One clock, async active-low reset
// Notes: Bound to every wtcts_top instance
`default_nettype none
module wtcts_asserts (
  // Clock, reset and APB
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Calendar and switch
  input wire logic rtc_valid_i,
  input wire logic [2:0] rtc_day_i,
  input wire logic [4:0] rtc_hour_i,
  input wire logic [5:0] rtc_min_i,
  input wire logic switch_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic setup;
  logic mapped;
  logic [14:0] prev;
  logic [3:0] age;
  assign setup = psel_i && !penable_i;
  assign mapped = paddr_i inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h18};
  // Cycles since the calendar inputs last moved, saturating
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev <= 15'h0000;
      age <= 4'h0;
    end else begin
      prev <= {rtc_valid_i, rtc_day_i, rtc_hour_i, rtc_min_i};
      if (prev != {rtc_valid_i, rtc_day_i, rtc_hour_i, rtc_min_i}) age <= 4'h0;
      else if (age != 4'hF) age <= age + 4'h1;
    end
  end
  a_ready_after_setup: assert property (setup |=> pready_o) else $error("no ready");
  a_ready_has_cause: assert property (pready_o |-> $past(setup)) else $error("stray ready");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o) else $error("long ready");
  a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("lone error");
  a_unmapped_err: assert property (setup && !mapped |=> pslverr_o) else $error("no error");
  a_mapped_ok: assert property (setup && mapped |=> !pslverr_o) else $error("false error");
  a_refused_zero: assert property (setup && !mapped && !pwrite_i |=> prdata_o == 32'h00000000)
    else $error("refused read data");
  a_switch_cause: assert property ($changed(switch_o) |-> age < 4'h8)
    else $error("switch moved without time change");
endmodule // wtcts_asserts
bind wtcts_top wtcts_asserts wtcts_asserts_inst (.clk_i, .arst_n_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .rtc_valid_i, .rtc_day_i,
  .rtc_hour_i, .rtc_min_i, .switch_o);
`default_nettype wire

// File: wtcts_rtc_model.sv
// Purpose: Calendar clock seen by the switch
// Assumes: Time is loaded by the bench, one minute per load
// Notes: Outputs hold between loads like a real minute counter
`default_nettype none
module wtcts_rtc_model (
  // Clock and load
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ld_i,
  input wire logic [2:0] day_i,
  input wire logic [4:0] hour_i,
  input wire logic [5:0] min_i,
  // Calendar outputs
  output logic rtc_valid_o,
  output logic [2:0] rtc_day_o,
  output logic [4:0] rtc_hour_o,
  output logic [5:0] rtc_min_o
);
  // Present calendar with weekday, hour and minute
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rtc_valid_o <= 1'b0;
      {rtc_day_o, rtc_hour_o, rtc_min_o} <= 14'h0000;
    end else if (ld_i) begin
      rtc_valid_o <= 1'b1;
      {rtc_day_o, rtc_hour_o, rtc_min_o} <= {day_i, hour_i, min_i};
    end
  end
endmodule // wtcts_rtc_model
`default_nettype wire

// File: wtcts_tb.sv
// Purpose: Self-checking bench for the weekly three cam time switch
// Assumes: 100 MHz clock, reset held 12 cycles
// Notes: Time changes land within a few cycles
`default_nettype none
module wtcts_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ld = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic pready, pslverr, e, rv, sw;
  logic [2:0] dd = 3'h0, rd;
  logic [4:0] hh = 5'h00, rh;
  logic [5:0] mm = 6'h00, rm;
  int miscompares = 0, checked = 0;
  always #5 clk = ~clk;
  wtcts_rtc_model wtcts_rtc_model_inst (.clk_i(clk), .arst_n_i(arst_n), .ld_i(ld),
    .day_i(dd), .hour_i(hh), .min_i(mm), .rtc_valid_o(rv), .rtc_day_o(rd),
    .rtc_hour_o(rh), .rtc_min_o(rm));
  wtcts_top wtcts_top_inst (.clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rtc_valid_i(rv), .rtc_day_i(rd),
    .rtc_hour_i(rh), .rtc_min_i(rm), .switch_o(sw));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    checked++;
    if (s !== x) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask
  function automatic logic [31:0] cw(input logic [6:0] dy, input logic [4:0] oh,
    input logic [5:0] om, input logic od, input logic [4:0] fh, input logic [5:0] fm,
    input logic fd);
    cw = {1'b0, fd, fh, fm, od, oh, om, dy};
  endfunction
  task automatic st(input logic [2:0] d, input logic [4:0] h, input logic [5:0] m);
    {ld, dd, hh, mm} <= {1'b1, d, h, m};
    @(posedge clk);
    ld <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h0, q);
    apb(1'b0, 8'h10, 32'h0);
    chk("cam reset", 32'h40040000, q);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    apb(1'b1, 8'h18, cw(7'h55, 5'h17, 6'h3B, 1'b0, 5'h00, 6'h00, 1'b1));
    apb(1'b0, 8'h18, 32'h0);
    chk("cam rw", cw(7'h55, 5'h17, 6'h3B, 1'b0, 5'h00, 6'h00, 1'b1), q);
  endtask
  task automatic t_onoff();
    apb(1'b1, 8'h10, cw(7'h02, 5'h07, 6'h00, 1'b0, 5'h00, 6'h00, 1'b1));
    apb(1'b1, 8'h14, cw(7'h08, 5'h00, 6'h00, 1'b1, 5'h0D, 6'h07, 1'b0));
    apb(1'b1, 8'h18, 32'h40040000);
    apb(1'b1, 8'h00, 32'h1);
    st(3'h0, 5'h07, 6'h00);
    chk("wrong day", 32'h0, {31'h0, sw});
    st(3'h1, 5'h07, 6'h00);
    chk("on", 32'h1, {31'h0, sw});
    st(3'h3, 5'h0D, 6'h06);
    chk("held", 32'h1, {31'h0, sw});
    st(3'h3, 5'h0D, 6'h07);
    chk("off", 32'h0, {31'h0, sw});
  endtask
  task automatic t_pulse();
    int n;
    int m;
    n = 0;
    m = 0;
    apb(1'b1, 8'h10, cw(7'h40, 5'h17, 6'h3B, 1'b0, 5'h17, 6'h3B, 1'b0));
    apb(1'b1, 8'h00, 32'h3);
    st(3'h6, 5'h17, 6'h3B);
    chk("pulse level", 32'h0, {31'h0, sw});
    {ld, dd, hh, mm} <= {1'b1, 3'h6, 5'h17, 6'h3A};
    @(posedge clk);
    ld <= 1'b0;
    repeat (12) @(posedge clk) n += (sw === 1'b1);
    chk("pulse", 32'h0, n);
    {ld, dd, hh, mm} <= {1'b1, 3'h6, 5'h17, 6'h3B};
    @(posedge clk);
    ld <= 1'b0;
    repeat (12) @(posedge clk) m += (sw === 1'b1);
    chk("pulse width", 32'h1, m);
    chk("pulse end", 32'h0, {31'h0, sw});
  endtask
  task automatic t_prio();
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h10, cw(7'h01, 5'h0A, 6'h00, 1'b0, 5'h00, 6'h00, 1'b1));
    apb(1'b1, 8'h14, cw(7'h01, 5'h00, 6'h00, 1'b1, 5'h0A, 6'h00, 1'b0));
    st(3'h0, 5'h0A, 6'h00);
    chk("cam2 wins", 32'h0, {31'h0, sw});
    apb(1'b1, 8'h18, cw(7'h01, 5'h0A, 6'h00, 1'b0, 5'h00, 6'h00, 1'b1));
    st(3'h0, 5'h09, 6'h3B);
    st(3'h0, 5'h0A, 6'h00);
    chk("cam3 wins", 32'h1, {31'h0, sw});
  endtask
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20us;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_onoff();
    t_pulse();
    t_prio();
    final_report();
  end
endmodule // wtcts_tb
`default_nettype wire
